//--- rtl/pbl_pkg.sv
// Contract
// - Hybrid 16-byte: wrap once, then linear onward
// - Code 110 repeats 16-byte aligned wrap
// - Code 100 repeats 128-byte aligned wrap
// - Code 101 repeats 64-byte aligned wrap
// - Codes 011 and 111 use 32-byte group
// - Burst type set gives plain increment
// - Latency before memory access and register read
// - Latency field selects three to seven clocks
// - Latency resets to seven clocks
// - Pending refresh raises strobe, adds latency
// - Register writes carry no latency at all
// - Refresh may overlap register write capture
// - Fixed latency: strobe high, two periods
// - Fixed latency active after reset
// - Variable mode: strobe high only for refresh
// - Drive strength field resets to zero
// - Strobe low one period, high two
// - Latency code table, others reserved
// - Hybrid bit: zero hybrid, one legacy
package pbl_pkg;

	// ----------------------------------------
	// Configuration register zero
	// ----------------------------------------
	localparam logic [15:0] CFG0_RST      = 16'h8F2F;
	localparam int          CFG_DRV_LSB   = 12;
	localparam int          CFG_DRV_MSB   = 14;
	localparam int          CFG_LAT_LSB   = 4;
	localparam int          CFG_LAT_MSB   = 7;
	localparam int          CFG_FIXED_BIT = 3;
	localparam int          CFG_HYB_BIT   = 2;
	localparam logic [31:0] CFG0_WADDR    = 32'h0000_0800;

	// ----------------------------------------
	// Burst lengths and group masks in words
	// ----------------------------------------
	localparam logic [1:0] BLEN_128     = 2'h0;
	localparam logic [1:0] BLEN_64      = 2'h1;
	localparam logic [1:0] BLEN_16      = 2'h2;
	localparam logic [6:0] GRP_MASK_128 = 7'h3F;
	localparam logic [6:0] GRP_MASK_64  = 7'h1F;
	localparam logic [6:0] GRP_MASK_32  = 7'h0F;
	localparam logic [6:0] GRP_MASK_16  = 7'h07;

	// ----------------------------------------
	// Initial latency codes and clock counts
	// ----------------------------------------
	localparam logic [3:0] LAT_CODE_3 = 4'hE;
	localparam logic [3:0] LAT_CODE_4 = 4'hF;
	localparam logic [3:0] LAT_CODE_5 = 4'h0;
	localparam logic [3:0] LAT_CODE_6 = 4'h1;
	localparam logic [3:0] LAT_CODE_7 = 4'h2;
	localparam logic [3:0] LAT_CLK_3  = 4'h3;
	localparam logic [3:0] LAT_CLK_4  = 4'h4;
	localparam logic [3:0] LAT_CLK_5  = 4'h5;
	localparam logic [3:0] LAT_CLK_6  = 4'h6;
	localparam logic [3:0] LAT_CLK_7  = 4'h7;

	// ----------------------------------------
	// Command-address phase layout
	// ----------------------------------------
	localparam logic [2:0] CA_LAST_EDGE = 3'h5;
	localparam int         CA_RD_BIT    = 47;
	localparam int         CA_REG_BIT   = 46;
	localparam int         CA_LIN_BIT   = 45;
	localparam int         CA_UP_MSB    = 44;
	localparam int         CA_UP_LSB    = 16;
	localparam int         CA_LOW_MSB   = 2;

	typedef struct packed {
		logic        rd;
		logic        reg_space;
		logic        linear;
		logic [31:0] waddr;
	} pbl_ca_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CA   = 3'h1,
		ST_LAT  = 3'h3,
		ST_DATA = 3'h2,
		ST_REGW = 3'h6,
		ST_DONE = 3'h7
	} pbl_state_t;

	// Reserved codes fall back to the slowest setting so timing stays safe
	function automatic logic [3:0] pbl_lat_clocks(input logic [3:0] code);
		case (code)
			LAT_CODE_3: pbl_lat_clocks = LAT_CLK_3;
			LAT_CODE_4: pbl_lat_clocks = LAT_CLK_4;
			LAT_CODE_5: pbl_lat_clocks = LAT_CLK_5;
			LAT_CODE_6: pbl_lat_clocks = LAT_CLK_6;
			default:    pbl_lat_clocks = LAT_CLK_7;
		endcase
	endfunction

endpackage

//--- rtl/pbl_addr_seq.sv
`timescale 1ns/1ps
module pbl_addr_seq #(
	parameter int AW = 21
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	input  wire logic          i_load,
	input  wire logic [AW-1:0] i_start,
	input  wire logic          i_linear,
	input  wire logic [2:0]    i_code,
	input  wire logic          i_step,
	output logic      [AW-1:0] o_addr
);
	import pbl_pkg::*;

	logic [AW-1:0] addr;
	logic [AW-1:0] start;
	logic [6:0]    cnt;
	logic          linear;
	logic          done;
	logic [2:0]    code;

	wire logic [6:0]    mask7;
	wire logic [AW-1:0] mask;
	wire logic [AW-1:0] grp_base;
	wire logic [AW-1:0] wrap_addr;
	wire logic [AW-1:0] grp_next;
	wire logic [AW-1:0] next_addr;
	wire logic          hybrid;
	wire logic          last_in_grp;

	// ----------------------------------------
	// Group size and next address
	// ----------------------------------------
	assign mask7 = (code[1:0] == BLEN_128) ? GRP_MASK_128 :
	               (code[1:0] == BLEN_64)  ? GRP_MASK_64  :
	               (code[1:0] == BLEN_16)  ? GRP_MASK_16  : GRP_MASK_32;
	assign mask        = AW'(mask7);
	assign grp_base    = addr & ~mask;
	assign wrap_addr   = grp_base | ((addr + AW'(1)) & mask);
	assign grp_next    = (start & ~mask) + mask + AW'(1);
	assign hybrid      = ~code[CFG_HYB_BIT];
	assign last_in_grp = hybrid && !done && (cnt == mask7);
	assign next_addr   = (linear || done) ? addr + AW'(1) :
	                     last_in_grp      ? grp_next : wrap_addr;
	assign o_addr      = addr;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			addr   <= '0;
			start  <= '0;
			cnt    <= '0;
			linear <= 1'b0;
			done   <= 1'b0;
			code   <= '0;
		end else if (i_load) begin
			addr   <= i_start;
			start  <= i_start;
			cnt    <= '0;
			linear <= i_linear;
			done   <= 1'b0;
			code   <= i_code;
		end else if (i_step) begin
			addr <= next_addr;
			cnt  <= cnt + 7'h01;
			if (last_in_grp)
				done <= 1'b1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_legacy_wrap_group: assert property (@(posedge i_clk) disable iff (i_rst)
		i_step && !i_load && !linear && !hybrid |=> grp_base == $past(grp_base))
		else $error("legacy wrap left its group");
	a_linear_increment: assert property (@(posedge i_clk) disable iff (i_rst)
		i_step && !i_load && linear |=> addr == $past(addr) + AW'(1))
		else $error("linear burst did not increment");
	a_hybrid_leave_group: assert property (@(posedge i_clk) disable iff (i_rst)
		i_step && !i_load && !linear && last_in_grp |=> addr == $past(grp_next) && done)
		else $error("hybrid burst did not move to next group");
	c_hybrid_done: cover property (@(posedge i_clk) disable iff (i_rst)
		i_step && last_in_grp);

	initial begin
		if (AW < 7 || AW > 32)
			$error("pbl_addr_seq: AW must be 7 to 32");
	end

endmodule // pbl_addr_seq

//--- rtl/pbl_psram_burst_latency_ctrl.sv
`timescale 1ns/1ps
module pbl_psram_burst_latency_ctrl #(
	parameter int AW = 21
) (
	input  wire logic          I_CLK,
	input  wire logic          I_RST,
	input  wire logic          I_CK,
	input  wire logic          I_CS_N,
	input  wire logic [7:0]    I_DQ,
	input  wire logic          I_REFRESH_PEND,
	output logic               O_RW_DATA_STROBE,
	output logic               O_RW_DATA_STROBE_OE,
	output logic      [15:0]   O_CFG0,
	output logic      [2:0]    O_DRIVE_STRENGTH,
	output logic               O_ARRAY_BUSY,
	output logic               O_WORD_STB,
	output logic               O_WORD_WR,
	output logic               O_WORD_REG,
	output logic      [AW-1:0] O_WORD_ADDR,
	output logic      [15:0]   O_WORD_DATA
);
	import pbl_pkg::*;

	// ----------------------------------------
	// Link input synchronisers
	// ----------------------------------------
	logic       ck_s1;
	logic       ck_s2;
	logic       ck_q;
	logic       cs_n_s1;
	logic       cs_n_s2;
	logic [7:0] dq_s1;
	logic [7:0] dq_s2;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ck_s1   <= 1'b0;
			ck_s2   <= 1'b0;
			ck_q    <= 1'b0;
			cs_n_s1 <= 1'b1;
			cs_n_s2 <= 1'b1;
			dq_s1   <= '0;
			dq_s2   <= '0;
		end else begin
			ck_s1   <= I_CK;
			ck_s2   <= ck_s1;
			ck_q    <= ck_s2;
			cs_n_s1 <= I_CS_N;
			cs_n_s2 <= cs_n_s1;
			dq_s1   <= I_DQ;
			dq_s2   <= dq_s1;
		end
	end

	// Data passes the same two stages as the clock, so it is stable at each edge
	wire logic ck_rise = ck_s2 & ~ck_q;
	wire logic ck_fall = ~ck_s2 & ck_q;
	wire logic ck_edge = ck_rise | ck_fall;
	wire logic cs_act  = ~cs_n_s2;

	// ----------------------------------------
	// State and storage
	// ----------------------------------------
	pbl_state_t  state;
	pbl_state_t  next_state;
	logic [15:0] cfg0;
	logic [39:0] ca_sh;
	logic [2:0]  ca_cnt;
	logic        rw_data_strobe_hi;
	logic [3:0]  lat_cnt;
	logic [7:0]  hi_byte;
	pbl_ca_t     ca;
	logic        word_stb;
	logic [15:0] word_data;
	logic        word_wr;
	logic        word_reg;

	wire logic [47:0]   ca_full  = {ca_sh, dq_s2};
	wire logic          cfg_fixed = cfg0[CFG_FIXED_BIT];
	wire logic [3:0]    cfg_lat   = cfg0[CFG_LAT_MSB:CFG_LAT_LSB];
	wire logic [3:0]    lat_clk   = pbl_lat_clocks(cfg_lat);
	wire logic [3:0]    lat_sel   = rw_data_strobe_hi ? {lat_clk[2:0], 1'b0} : lat_clk;
	wire logic          enter_ca  = (state == ST_IDLE) && cs_act;
	wire logic          ca_done   = (state == ST_CA) && ck_edge && (ca_cnt == CA_LAST_EDGE);
	wire pbl_ca_t       ca_dec;
	wire logic          is_regw   = ca_dec.reg_space && !ca_dec.rd;
	wire logic          lat_last  = (state == ST_LAT) && ck_fall && (lat_cnt == 4'h0);
	wire logic          data_word = (state == ST_DATA) && ck_fall;
	wire logic          cfg_hit   = (ca.waddr == CFG0_WADDR);
	wire logic [AW-1:0] seq_addr;

	assign ca_dec.rd        = ca_full[CA_RD_BIT];
	assign ca_dec.reg_space = ca_full[CA_REG_BIT];
	assign ca_dec.linear    = ca_full[CA_LIN_BIT];
	assign ca_dec.waddr     = {ca_full[CA_UP_MSB:CA_UP_LSB], ca_full[CA_LOW_MSB:0]};

	// ----------------------------------------
	// Transaction sequence
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (cs_act)
					next_state = ST_CA;
			end
			ST_CA: begin
				if (ca_done)
					next_state = is_regw ? ST_REGW : ST_LAT;
			end
			ST_LAT: begin
				if (lat_last)
					next_state = ST_DATA;
			end
			ST_DATA: begin
				next_state = ST_DATA;
			end
			ST_REGW: begin
				if (ck_fall)
					next_state = ST_DONE;
			end
			default: begin
				next_state = ST_DONE;
			end
		endcase
		if (!cs_act)
			next_state = ST_IDLE;
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Strobe level is chosen at select time: fixed mode or a pending refresh
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			rw_data_strobe_hi <= 1'b0;
		else if (enter_ca)
			rw_data_strobe_hi <= cfg_fixed | I_REFRESH_PEND;
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ca_sh  <= '0;
			ca_cnt <= '0;
		end else if (enter_ca) begin
			ca_cnt <= '0;
		end else if ((state == ST_CA) && ck_edge) begin
			ca_sh  <= ca_full[39:0];
			ca_cnt <= ca_cnt + 3'h1;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			ca <= '0;
		else if (ca_done)
			ca <= ca_dec;
	end

	// A high strobe (fixed mode or refresh) doubles the wait; counted on rising edges, left on the last falling edge
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			lat_cnt <= '0;
		else if (ca_done)
			lat_cnt <= lat_sel;
		else if ((state == ST_LAT) && ck_rise)
			lat_cnt <= lat_cnt - 4'h1;
	end

	// ----------------------------------------
	// Configuration register zero
	// ----------------------------------------
	// Register write data is taken right after the address, no wait at all
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			cfg0 <= CFG0_RST;
		else if ((state == ST_REGW) && ck_fall && cfg_hit)
			cfg0 <= {hi_byte, dq_s2};
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			hi_byte <= '0;
		else if (((state == ST_DATA) || (state == ST_REGW)) && ck_rise)
			hi_byte <= dq_s2;
	end

	// ----------------------------------------
	// Word stream and address sequencer
	// ----------------------------------------
	pbl_addr_seq #(
		.AW (AW)
	) u_seq (
		.i_clk    (I_CLK),
		.i_rst    (I_RST),
		.i_load   (ca_done),
		.i_start  (ca_dec.waddr[AW-1:0]),
		.i_linear (ca_dec.linear),
		.i_code   (cfg0[2:0]),
		.i_step   (data_word),
		.o_addr   (seq_addr)
	);

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			word_stb    <= 1'b0;
			word_data   <= '0;
			word_wr     <= 1'b0;
			word_reg    <= 1'b0;
			O_WORD_ADDR <= '0;
		end else begin
			word_stb <= data_word;
			if (data_word) begin
				word_data   <= {hi_byte, dq_s2};
				word_wr     <= !ca.rd;
				word_reg    <= ca.reg_space;
				O_WORD_ADDR <= seq_addr;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign O_RW_DATA_STROBE           = rw_data_strobe_hi;
	assign O_RW_DATA_STROBE_OE        = (state == ST_CA);
	assign O_CFG0           = cfg0;
	assign O_DRIVE_STRENGTH = cfg0[CFG_DRV_MSB:CFG_DRV_LSB];
	// Array stays free during register writes so a refresh can run alongside
	assign O_ARRAY_BUSY     = (state == ST_LAT) || (state == ST_DATA);
	assign O_WORD_STB       = word_stb;
	assign O_WORD_WR        = word_wr;
	assign O_WORD_REG       = word_reg;
	assign O_WORD_DATA      = word_data;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_fixed_strobe_high: assert property (@(posedge I_CLK) disable iff (I_RST)
		enter_ca && cfg_fixed |=> O_RW_DATA_STROBE && O_RW_DATA_STROBE_OE)
		else $error("fixed latency did not drive strobe high");
	a_var_strobe_level: assert property (@(posedge I_CLK) disable iff (I_RST)
		enter_ca && !cfg_fixed |=> O_RW_DATA_STROBE == $past(I_REFRESH_PEND))
		else $error("variable strobe level wrong");
	a_reset_config: assert property (@(posedge I_CLK) disable iff (I_RST)
		$fell(I_RST) |-> cfg_fixed && lat_clk == LAT_CLK_7 && O_DRIVE_STRENGTH == 3'h0)
		else $error("config not at reset value");
	a_latency_load: assert property (@(posedge I_CLK) disable iff (I_RST)
		ca_done && !is_regw && cs_act |=> state == ST_LAT && lat_cnt == $past(lat_sel))
		else $error("latency count not loaded");
	a_latency_double: assert property (@(posedge I_CLK) disable iff (I_RST)
		ca_done && !is_regw && rw_data_strobe_hi && cs_act |=> lat_cnt == {$past(lat_clk[2:0]), 1'b0})
		else $error("strobe high did not double latency");
	a_regw_zero_lat: assert property (@(posedge I_CLK) disable iff (I_RST)
		ca_done && is_regw && cs_act |=> state == ST_REGW)
		else $error("register write got latency");
	a_lat_code_table: assert property (@(posedge I_CLK) disable iff (I_RST)
		(cfg_lat == LAT_CODE_3 |-> lat_clk == LAT_CLK_3) and
		(cfg_lat == LAT_CODE_6 |-> lat_clk == LAT_CLK_6))
		else $error("latency code decode wrong");
	a_lat_to_data: assert property (@(posedge I_CLK) disable iff (I_RST)
		lat_last && cs_act |=> state == ST_DATA ##0 !O_WORD_STB)
		else $error("latency end did not open data");
	a_regw_array_free: assert property (@(posedge I_CLK) disable iff (I_RST)
		state == ST_REGW |-> !O_ARRAY_BUSY)
		else $error("array busy during register write");
	c_fixed_data: cover property (@(posedge I_CLK) disable iff (I_RST)
		cfg_fixed && lat_last);
	c_reg_write: cover property (@(posedge I_CLK) disable iff (I_RST)
		(state == ST_REGW) && ck_fall && cfg_hit);
	c_refresh_var: cover property (@(posedge I_CLK) disable iff (I_RST)
		enter_ca && !cfg_fixed && I_REFRESH_PEND);

	initial begin
		if (AW < 7 || AW > 32)
			$error("pbl_psram_burst_latency_ctrl: AW must be 7 to 32");
	end

endmodule // pbl_psram_burst_latency_ctrl

//--- tb/pbl_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host controller on the link
// ----------------------------------------
module pbl_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_rw_data_strobe,
	input  wire logic       i_rw_data_strobe_oe,
	output logic            o_ck,
	output logic      [7:0] o_dq,
	output logic            o_cs_n
);
	logic rw_data_strobe_seen;
	initial begin
		o_ck = 1'b0;
		o_cs_n = 1'b1;
		o_dq = 8'h00;
		rw_data_strobe_seen = 1'b0;
	end
	// Data settles four cycles before the edge so synchroniser skew cannot split them
	task automatic half(input logic [7:0] b);
		@(posedge i_clk);
		o_dq <= b;
		repeat (4) @(posedge i_clk);
		o_ck <= ~o_ck;
		repeat (3) @(posedge i_clk);
	endtask
	task automatic xfer(input logic [47:0] ca, input int lat, input int nw, input logic [15:0] wd);
		int          per;
		logic [15:0] w;
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		for (int k = 5; k >= 0; k--) begin
			half(ca[8*k +: 8]);
			if (k == 4)
				rw_data_strobe_seen = (i_rw_data_strobe_oe === 1'b1) ? i_rw_data_strobe : 1'bx;
		end
		per = (ca[46] && !ca[47]) ? 0 : (rw_data_strobe_seen ? 2 * lat : lat);
		// Latency and read slots carry a toggling pattern, never a stale byte
		for (int k = 0; k < 2 * per; k++)
			half(~o_dq);
		for (int k = 0; k < nw; k++) begin
			w = wd + 16'(k);
			half(ca[47] ? ~o_dq : w[15:8]);
			half(ca[47] ? ~o_dq : w[7:0]);
		end
		repeat (4) @(posedge i_clk);
		o_cs_n <= 1'b1;
		o_dq <= ~o_dq;
		repeat (8) @(posedge i_clk);
	endtask
endmodule // pbl_host_model

//--- tb/pbl_psram_burst_latency_ctrl_tb.sv
`timescale 1ns/1ps
module pbl_psram_burst_latency_ctrl_tb;
	import pbl_pkg::*;
	logic        clk, rst, ck, cs_n, pend, rw_data_strobe, rw_data_strobe_oe, busy, stb, wr, rg, busy_seen;
	logic [7:0]  dq;
	logic [15:0] cfg0, data, cfg;
	logic [2:0]  drv;
	logic [20:0] addr;
	logic [20:0] q_addr[$];
	logic [15:0] q_data[$];
	logic        q_wr[$];
	logic        q_reg[$];
	int          err_count, checked;
	// ----------------------------------------
	// Cases: config, pend/rd/reg/lin, start, words
	// ----------------------------------------
	localparam logic [35:0] TBL [8] = '{
		{16'hDFE2, 4'h0, 8'h0C, 8'h0C},
		{16'h8FF6, 4'hC, 8'h0C, 8'h0A},
		{16'h8F0C, 4'h0, 8'h03, 8'h42},
		{16'h8F15, 4'h4, 8'h2E, 8'h22},
		{16'h8F23, 4'h0, 8'h0A, 8'h12},
		{16'h8F57, 4'hC, 8'h1E, 8'h10},
		{16'h8FE2, 4'h1, 8'h03, 8'h14},
		{16'h8FE2, 4'h6, 8'h00, 8'h02}
	};
	pbl_psram_burst_latency_ctrl #(.AW(21)) i_dut (
		.I_CLK(clk), .I_RST(rst), .I_CK(ck), .I_CS_N(cs_n), .I_DQ(dq),
		.I_REFRESH_PEND(pend), .O_RW_DATA_STROBE(rw_data_strobe), .O_RW_DATA_STROBE_OE(rw_data_strobe_oe), .O_CFG0(cfg0),
		.O_DRIVE_STRENGTH(drv), .O_ARRAY_BUSY(busy), .O_WORD_STB(stb), .O_WORD_WR(wr),
		.O_WORD_REG(rg), .O_WORD_ADDR(addr), .O_WORD_DATA(data));
	pbl_host_model i_host (.i_clk(clk), .i_rw_data_strobe(rw_data_strobe), .i_rw_data_strobe_oe(rw_data_strobe_oe), .o_ck(ck),
		.o_dq(dq), .o_cs_n(cs_n));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (stb === 1'b1) begin
			q_addr.push_back(addr);
			q_data.push_back(data);
			q_wr.push_back(wr);
			q_reg.push_back(rg);
		end
		if (busy === 1'b1)
			busy_seen = 1'b1;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	function automatic logic [47:0] mk_ca(input logic rd, input logic rs, input logic ln,
			input logic [31:0] a);
		mk_ca = {rd, rs, ln, a[31:3], 13'h0000, a[2:0]};
	endfunction
	function automatic int lat_clk(input logic [3:0] c);
		case (c)
			4'hE: lat_clk = 3;
			4'hF: lat_clk = 4;
			4'h0: lat_clk = 5;
			4'h1: lat_clk = 6;
			default: lat_clk = 7;
		endcase
	endfunction
	// Group size follows the length field; hybrid only differs once the first group is done
	function automatic logic [31:0] exp_addr(input logic [31:0] a, input int i, input logic ln);
		logic [31:0] n, base;
		n = (cfg[1:0] == 2'h0) ? 32'h0000_0040 : (cfg[1:0] == 2'h1) ? 32'h0000_0020 :
			(cfg[1:0] == 2'h2) ? 32'h0000_0008 : 32'h0000_0010;
		base = a & ~(n - 32'h0000_0001);
		if (ln)
			exp_addr = a + 32'(i);
		else if (!cfg[2] && i >= n)
			exp_addr = base + 32'(i);
		else
			exp_addr = base + ((a + 32'(i)) & (n - 32'h0000_0001));
	endfunction
	task automatic run(input logic rd, input logic rs, input logic ln, input logic [31:0] a,
			input int nw, input logic [15:0] wd);
		logic exp_rw_data_strobe;
		exp_rw_data_strobe = cfg[3] | pend;
		q_addr.delete();
		q_data.delete();
		q_wr.delete();
		q_reg.delete();
		busy_seen = 1'b0;
		i_host.xfer(mk_ca(rd, rs, ln, a), lat_clk(cfg[7:4]), nw, wd);
		cmp_bit(i_host.rw_data_strobe_seen, exp_rw_data_strobe, "strobe");
		cmp_bit(busy_seen, !(rs && !rd), "busy");
		// Register writes land in the configuration only, never on the word stream
		cmp_val(32'(q_addr.size()), (rs && !rd) ? 32'h0000_0000 : 32'(nw), "words");
		foreach (q_addr[i]) begin
			if (!rs)
				cmp_val(32'(q_addr[i]), exp_addr(a, i, ln), "addr");
			if (!rd)
				cmp_val(32'(q_data[i]), 32'(wd + 16'(i)), "data");
			cmp_bit(q_wr[i], !rd, "wr flag");
			cmp_bit(q_reg[i], rs, "reg flag");
		end
	endtask
	task automatic cfg_w(input logic [15:0] v);
		run(1'b0, 1'b1, 1'b0, CFG0_WADDR, 1, v);
		cfg = v;
		cmp_val(32'(cfg0), 32'(v), "config");
		cmp_val(32'(drv), 32'(v[14:12]), "drive");
	endtask
	task automatic print_verdict();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		pend = 1'b0;
		cfg = 16'h8F2F;
		err_count = 0;
		checked = 0;
		busy_seen = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		cmp_val(32'(cfg0), 32'h0000_8F2F, "reset config");
		cmp_val(32'(drv), 32'h0000_0000, "reset drive");
		run(1'b1, 1'b0, 1'b0, 32'h0000_000A, 16, 16'h0000);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			pend <= TBL[k][19];
			@(posedge clk);
			cfg_w(TBL[k][35:20]);
			run(TBL[k][18], TBL[k][17], TBL[k][16], 32'(TBL[k][15:8]), int'(TBL[k][7:0]),
				16'h3C00 + 16'(k));
			$display("test %0d done", k);
		end
		// A register write elsewhere must leave the configuration alone
		i_host.xfer(mk_ca(1'b0, 1'b1, 1'b0, CFG0_WADDR + 32'h0000_0001), 0, 1, 16'h0000);
		cmp_val(32'(cfg0), 32'(cfg), "stray write");
		$display("test stray write done");
		print_verdict();
	end
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		$display("MISMATCH %0t run did not finish", $time);
		print_verdict();
	end
endmodule // pbl_psram_burst_latency_ctrl_tb
